//--- rtl/pis_pkg.sv
// Package for the prioritized interrupt system: types, codes and constants
// Behaviour
// - Status word bits 1..7 gate external, malfunction, divide, auto I/O, float, end, protect
// - Bit set permits its type; illegal, queue overflow, supervisor call cannot be inhibited
// - Servicing saves old status word for that type, then loads the new one
// - Controller queue flip-flop holds an interrupt until acknowledged unless disarmed
// - Disabled but armed controller still queues, only withholds the request
// - With bit 7 set a privileged instruction traps instead of executing
// - On that trap the location counter does not advance
// - Guarded writes always suppressed; guard interrupt needs armed and bit 1
// - Device address field is eight bits wide, 256 controllers
// - Bus position fixes priority; nearest controller ranks highest
// - Acknowledge pulse stops at first queued controller, which returns its address
// - Microcode acknowledges with bits 1 and 4; instruction acknowledges with 1 only
// - External module takes eight inputs, one device address each
// - Jumper base is 0x20, 0x28, 0x30 or 0x38; input n answers at base plus n
// - Writes to the base address alternate arm byte then mask byte
// - Initialize or an output command disarms and masks all, restarts at arm byte
// - Data bit n controls input n; input 0 ranks highest in the module
// - Queue flip-flop sets on relay energizing only while its arm bit is one
// - Queued input presented only while mask bit one; serviced only with bit 1
package pis_pkg;
    localparam int ADDR_W = 8;
    localparam int NUM_EXT = 8;
    localparam int TYPE_W = 4;
    localparam int LOC_W = 16;
    // Status word control bit positions
    localparam int PSW_EXT_BIT = 1;
    localparam int PSW_AUTO_BIT = 4;
    localparam int PSW_PROT_BIT = 7;
    // Interrupt type codes; codes 1..7 equal their inhibit bit position
    localparam logic [3:0] TY_NONE = 4'h0;
    localparam logic [3:0] TY_EXT = 4'h1;
    localparam logic [3:0] TY_MALF = 4'h2;
    localparam logic [3:0] TY_DIV = 4'h3;
    localparam logic [3:0] TY_FLT = 4'h5;
    localparam logic [3:0] TY_TERM = 4'h6;
    localparam logic [3:0] TY_PROT = 4'h7;
    localparam logic [3:0] TY_ILL = 4'h8;
    localparam logic [3:0] TY_TQO = 4'h9;
    localparam logic [3:0] TY_SVC = 4'hA;
    localparam logic [3:0] TY_LAST_GATED = 4'h7;
    // Jumper base addresses of the external interrupt module
    localparam logic [7:0] EXT_BASE_0 = 8'h20;
    localparam logic [7:0] EXT_BASE_1 = 8'h28;
    localparam logic [7:0] EXT_BASE_2 = 8'h30;
    localparam logic [7:0] EXT_BASE_3 = 8'h38;
    localparam logic [7:0] EXT_SPAN_MASK = 8'hF8;
    // Reset values
    localparam logic [7:0] PSW_CTL_RST = 8'h00;
    localparam logic [15:0] PSW_LOC_RST = 16'h0000;
    localparam logic [7:0] ARM_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'h00;

    typedef enum logic [1:0] {
        PIS_IDLE = 2'b00,
        PIS_SAVE = 2'b01,
        PIS_LOAD = 2'b11
    } pis_state_t;

    typedef struct packed {
        logic [7:0] ctl;
        logic [15:0] loc;
    } pis_psw_t;

    typedef struct packed {
        logic malf;
        logic div;
        logic flt;
        logic term;
        logic ill;
        logic tqo;
        logic svc;
    } pis_evt_t;

    typedef struct packed {
        logic wr;
        logic cmd;
        logic [7:0] addr;
        logic [7:0] data;
    } pis_io_t;
endpackage : pis_pkg

//--- rtl/pis_core.sv
// Interrupt gating, status word swap, protect trap, write guard and external module
`timescale 1ns/10ps
`default_nettype none
module pis_core import pis_pkg::*; #(
    parameter logic [7:0] GUARD_ADDR = 8'hAE
) (
    input wire logic i_clk_sys, // System clock
    input wire logic i_rst, // Initialize, async high
    input wire logic i_ce, // Clock enable
    input wire pis_evt_t i_evt, // Internal interrupt events, pulses
    input wire logic i_instr_valid, // Instruction issue pulse
    input wire logic i_instr_priv, // Issued instruction is privileged
    input wire logic [15:0] i_instr_len, // Bytes to advance location counter
    input wire logic i_ack_instr, // Acknowledge instruction executed
    input wire pis_psw_t i_new_psw, // New status word from memory
    input wire logic i_new_psw_valid, // New status word present
    input wire pis_io_t i_io, // Bus write/command strobes
    input wire logic [7:0] i_relay, // External relay inputs (pins)
    input wire logic [1:0] i_base_sel, // Base address jumpers (pins)
    input wire logic i_mem_wr, // Core write request
    input wire logic i_guard_hit, // Write falls in guarded area
    input wire logic i_guard_arm, // Guard interrupt armed
    input wire logic i_guard_en, // Guard interrupt enabled
    input wire logic i_down_req, // Request from farther controllers
    input wire logic i_down_valid, // Farther controller returned address
    input wire logic [7:0] i_down_addr, // Address from farther controller
    output logic o_busy, // Swap sequence in progress
    output logic o_instr_exec, // Issued instruction executes
    output logic o_swap_save, // Old status word store pulse
    output logic [3:0] o_swap_type, // Type of serviced interrupt
    output pis_psw_t o_old_psw, // Status word being saved
    output pis_psw_t o_psw, // Current status word
    output logic o_mem_wr_en, // Core write actually performed
    output logic o_ack_down, // Acknowledge passed down the bus
    output logic o_ack_valid, // Acknowledge answer pulse
    output logic [7:0] o_ack_addr // Address of acknowledged controller
);
    pis_state_t state, next_state;
    logic busy, next_busy;
    pis_psw_t processor_status_word, next_psw;
    logic [15:0] pend, next_pend;
    logic [7:0] arm, next_arm, mask, next_mask, queue, next_queue;
    logic seq_mask, next_seq_mask, guard_q, next_guard_q;
    logic ack_busy, next_ack_busy;
    logic [7:0] relay_s1, relay_s2, relay_d;
    logic [1:0] base_s1, base_s2;
    logic instr_exec, next_instr_exec, swap_save, next_swap_save;
    logic [3:0] swap_type, next_swap_type;
    pis_psw_t old_psw, next_old_psw;
    logic mem_wr_en, next_mem_wr_en, ack_down, next_ack_down;
    logic ack_valid, next_ack_valid;
    logic [7:0] ack_addr, next_ack_addr;
    logic [7:0] base, present;
    logic attn, ack_now, io_hit_mod, io_hit_base;
    logic [3:0] win;
    logic [15:0] evt_vec;

    // Relay and jumper pins cross in through two flip-flops
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            relay_s1 <= 8'h00;
            relay_s2 <= 8'h00;
            relay_d <= 8'h00;
            base_s1 <= 2'h0;
            base_s2 <= 2'h0;
        end else if (i_ce) begin
            relay_s1 <= i_relay;
            relay_s2 <= relay_s1;
            relay_d <= relay_s2;
            base_s1 <= i_base_sel;
            base_s2 <= base_s1;
        end
    end

    // Module base address from jumpers, eight consecutive addresses
    always_comb begin
        case (base_s2)
            2'h0: base = EXT_BASE_0;
            2'h1: base = EXT_BASE_1;
            2'h2: base = EXT_BASE_2;
            2'h3: base = EXT_BASE_3;
            default: base = EXT_BASE_0;
        endcase
        io_hit_mod = (i_io.addr & EXT_SPAN_MASK) == base;
        io_hit_base = i_io.addr == base;
        present = queue & mask;
        attn = guard_q & i_guard_en | (|present) | i_down_req;
    end

    // Internal events as a type-indexed vector
    always_comb begin
        evt_vec = 16'h0000;
        evt_vec[TY_MALF] = i_evt.malf;
        evt_vec[TY_DIV] = i_evt.div;
        evt_vec[TY_FLT] = i_evt.flt;
        evt_vec[TY_TERM] = i_evt.term;
        evt_vec[TY_ILL] = i_evt.ill;
        evt_vec[TY_TQO] = i_evt.tqo;
        evt_vec[TY_SVC] = i_evt.svc;
    end

    // Lowest permitted pending type wins; types above 7 have no inhibit bit
    always_comb begin
        win = TY_NONE;
        for (int t = 15; t >= 1; t--) begin
            if (pend[t] && (t > int'(TY_LAST_GATED) || processor_status_word.ctl[3'(t)])) begin
                win = 4'(t);
            end
        end
        if (attn && processor_status_word.ctl[PSW_EXT_BIT] && !processor_status_word.ctl[PSW_AUTO_BIT] &&
            (win == TY_NONE || win > TY_EXT)) begin
            win = TY_EXT;
        end
    end

    // Acknowledge from microcode in auto mode, else from the instruction
    always_comb begin
        ack_now = 1'b0;
        if (processor_status_word.ctl[PSW_EXT_BIT] && !ack_busy) begin
            if (processor_status_word.ctl[PSW_AUTO_BIT]) begin
                ack_now = attn && state == PIS_IDLE;
            end else begin
                ack_now = i_ack_instr;
            end
        end
    end

    // Sequencer, status word, pending flags and instruction handling
    always_comb begin
        next_state = state;
        next_psw = processor_status_word;
        next_pend = pend;
        next_instr_exec = 1'b0;
        next_swap_save = 1'b0;
        next_swap_type = swap_type;
        next_old_psw = old_psw;
        case (state)
            PIS_IDLE: begin
                if (win != TY_NONE) begin
                    next_swap_type = win;
                    next_state = PIS_SAVE;
                end else if (i_instr_valid) begin
                    if (i_instr_priv && processor_status_word.ctl[PSW_PROT_BIT]) begin
                        next_pend[TY_PROT] = 1'b1;
                    end else begin
                        next_instr_exec = 1'b1;
                        next_psw.loc = processor_status_word.loc + i_instr_len;
                    end
                end
            end
            PIS_SAVE: begin
                next_old_psw = processor_status_word;
                next_swap_save = 1'b1;
                next_pend[swap_type] = 1'b0;
                next_state = PIS_LOAD;
            end
            PIS_LOAD: begin
                if (i_new_psw_valid) begin
                    next_psw = i_new_psw;
                    next_state = PIS_IDLE;
                end
            end
            default: next_state = PIS_IDLE;
        endcase
        next_pend = next_pend | evt_vec; // Set wins over clear
        next_pend[TY_EXT] = 1'b0;
        next_busy = next_state != PIS_IDLE; // Registered so the output leaves a flip-flop
    end

    // External module registers, queue flip-flops and the acknowledge chain
    always_comb begin
        next_arm = arm;
        next_mask = mask;
        next_seq_mask = seq_mask;
        next_queue = queue;
        next_guard_q = guard_q;
        next_ack_busy = ack_busy;
        next_ack_down = 1'b0;
        next_ack_valid = 1'b0;
        next_ack_addr = ack_addr;
        next_mem_wr_en = i_mem_wr && !i_guard_hit;
        if (i_io.cmd && io_hit_mod) begin
            next_arm = ARM_RST;
            next_mask = MASK_RST;
            next_seq_mask = 1'b0;
        end else if (i_io.wr && io_hit_base) begin
            if (seq_mask) begin
                next_mask = i_io.data;
            end else begin
                next_arm = i_io.data;
            end
            next_seq_mask = !seq_mask;
        end
        if (ack_now) begin
            if (guard_q && i_guard_en) begin
                next_guard_q = 1'b0;
                next_ack_addr = GUARD_ADDR;
                next_ack_valid = 1'b1;
            end else if (|present) begin
                for (int n = NUM_EXT - 1; n >= 0; n--) begin
                    if (present[n]) begin
                        next_ack_addr = base + 8'(n);
                    end
                end
                next_queue = queue & ~(present & (~present + 8'h01));
                next_ack_valid = 1'b1;
            end else begin
                next_ack_down = 1'b1;
                next_ack_busy = 1'b1;
            end
        end
        if (ack_busy && i_down_valid) begin
            next_ack_busy = 1'b0;
            next_ack_addr = i_down_addr;
            next_ack_valid = 1'b1;
        end
        next_queue = (next_queue | (relay_s2 & ~relay_d & arm)) & next_arm;
        next_guard_q = (next_guard_q | (i_mem_wr && i_guard_hit)) && i_guard_arm;
    end

    // State registers
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            state <= PIS_IDLE;
            busy <= 1'b0;
            processor_status_word <= '{ctl: PSW_CTL_RST, loc: PSW_LOC_RST};
            pend <= 16'h0000;
            arm <= ARM_RST;
            mask <= MASK_RST;
            seq_mask <= 1'b0;
            queue <= 8'h00;
            guard_q <= 1'b0;
            ack_busy <= 1'b0;
            instr_exec <= 1'b0;
            swap_save <= 1'b0;
            swap_type <= TY_NONE;
            old_psw <= '{ctl: PSW_CTL_RST, loc: PSW_LOC_RST};
            mem_wr_en <= 1'b0;
            ack_down <= 1'b0;
            ack_valid <= 1'b0;
            ack_addr <= 8'h00;
        end else if (i_ce) begin
            state <= next_state;
            busy <= next_busy;
            processor_status_word <= next_psw;
            pend <= next_pend;
            arm <= next_arm;
            mask <= next_mask;
            seq_mask <= next_seq_mask;
            queue <= next_queue;
            guard_q <= next_guard_q;
            ack_busy <= next_ack_busy;
            instr_exec <= next_instr_exec;
            swap_save <= next_swap_save;
            swap_type <= next_swap_type;
            old_psw <= next_old_psw;
            mem_wr_en <= next_mem_wr_en;
            ack_down <= next_ack_down;
            ack_valid <= next_ack_valid;
            ack_addr <= next_ack_addr;
        end
    end

    // Outputs straight from flip-flops
    assign o_busy = busy;
    assign o_instr_exec = instr_exec;
    assign o_swap_save = swap_save;
    assign o_swap_type = swap_type;
    assign o_old_psw = old_psw;
    assign o_psw = processor_status_word;
    assign o_mem_wr_en = mem_wr_en;
    assign o_ack_down = ack_down;
    assign o_ack_valid = ack_valid;
    assign o_ack_addr = ack_addr;

    // Checks
    AST_PROT_TRAP: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_ce && state == PIS_IDLE && win == TY_NONE && i_instr_valid && i_instr_priv
        && processor_status_word.ctl[PSW_PROT_BIT] |=> !instr_exec && pend[TY_PROT])
        else $error("privileged instruction not trapped");
    AST_LOC_HOLD: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_ce && state == PIS_IDLE && !instr_exec ##1 !instr_exec && state == PIS_IDLE
        |-> processor_status_word.loc == $past(processor_status_word.loc))
        else $error("location counter moved without execution");
    AST_GUARD_WR: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_ce && i_mem_wr && i_guard_hit |=> !mem_wr_en)
        else $error("guarded write performed");
    AST_SWAP_SEQ: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        swap_save |-> state == PIS_LOAD && old_psw == $past(processor_status_word))
        else $error("old status word not saved before load");
    AST_GATE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_ce && state == PIS_IDLE && win != TY_NONE |=> state == PIS_SAVE
        && (swap_type > TY_LAST_GATED || processor_status_word.ctl[swap_type[2:0]]))
        else $error("inhibited type serviced");
    AST_INIT_SEQ: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_ce && i_io.cmd && io_hit_mod |=> arm == 8'h00 && mask == 8'h00 && !seq_mask)
        else $error("module not initialized by command");
    AST_ARM_GATE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (queue & ~arm) == 8'h00)
        else $error("queue set on disarmed input");
    AST_ACK_CLEAR: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_ce && ack_now && !(guard_q && i_guard_en) && present[0] |=> ack_valid
        && ack_addr == base && !queue[0])
        else $error("acknowledged input 0 not cleared");
    AST_ACK_SRC: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_ce && i_ack_instr && processor_status_word.ctl[PSW_EXT_BIT] && !processor_status_word.ctl[PSW_AUTO_BIT] && !ack_busy
        && attn |=> ack_valid || ack_down)
        else $error("acknowledge instruction ignored");
endmodule : pis_core
`default_nettype wire

//--- testbench/pis_bus_partner.sv
// Model of a farther controller on the bus acknowledge chain
`timescale 1ns/10ps
`default_nettype none
module pis_bus_partner #(
    parameter logic [7:0] DEV_ADDR = 8'h5C,
    parameter int DELAY = 3
) (
    input wire logic i_clk_sys, // System clock
    input wire logic i_rst, // Initialize, async high
    input wire logic i_post, // Event that queues an interrupt
    input wire logic i_ack, // Acknowledge pulse from upstream
    output logic o_req, // Queued request towards processor
    output logic o_valid, // Address answer pulse
    output logic [7:0] o_addr // Returned address, scrambled when idle
);
    int cnt;
    // Queue flip-flop stops the pulse and answers after a delay
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_req <= 1'b0;
            o_valid <= 1'b0;
            o_addr <= 8'h00;
            cnt <= 0;
        end else begin
            if (i_post) begin
                o_req <= 1'b1;
            end
            if (i_ack && o_req && cnt == 0) begin
                cnt <= DELAY;
            end else if (cnt > 0) begin
                cnt <= cnt - 1;
            end
            if (cnt == 1) begin
                o_valid <= 1'b1;
                o_addr <= DEV_ADDR;
                o_req <= 1'b0;
            end else begin
                o_valid <= 1'b0;
                o_addr <= ~o_addr; // Released lines invert every cycle, so the last address returns every other cycle
            end
        end
    end
endmodule : pis_bus_partner
`default_nettype wire

//--- testbench/prioritized_interrupt_system_tb.sv
// Self-checking testbench for the prioritized interrupt system core
`timescale 1ns/10ps
`default_nettype none
module prioritized_interrupt_system_tb import pis_pkg::*;;
    localparam logic [7:0] GUARD = 8'hAE;
    logic clk, rst, ce, instr_valid, instr_priv, ack_instr, new_psw_valid, mem_wr;
    logic guard_hit, guard_arm, guard_en, post, p_req, p_valid;
    logic o_busy, o_instr_exec, o_swap_save, o_mem_wr_en, o_ack_down, o_ack_valid;
    logic [15:0] instr_len;
    logic [7:0] relay, p_addr, o_ack_addr;
    logic [3:0] o_swap_type;
    logic [1:0] base_sel;
    pis_evt_t evt;
    pis_psw_t new_psw, o_old_psw, o_psw;
    pis_io_t io;
    int fails = 0, cmp_count = 0, exec_cnt = 0, ack_cnt = 0, down_cnt = 0, wr_cnt = 0;

    pis_core #(.GUARD_ADDR(GUARD)) i_dut (.i_clk_sys(clk), .i_rst(rst), .i_ce(ce),
        .i_evt(evt), .i_instr_valid(instr_valid), .i_instr_priv(instr_priv),
        .i_instr_len(instr_len), .i_ack_instr(ack_instr), .i_new_psw(new_psw),
        .i_new_psw_valid(new_psw_valid), .i_io(io), .i_relay(relay), .i_base_sel(base_sel),
        .i_mem_wr(mem_wr), .i_guard_hit(guard_hit), .i_guard_arm(guard_arm),
        .i_guard_en(guard_en), .i_down_req(p_req), .i_down_valid(p_valid),
        .i_down_addr(p_addr), .o_busy(o_busy), .o_instr_exec(o_instr_exec),
        .o_swap_save(o_swap_save), .o_swap_type(o_swap_type), .o_old_psw(o_old_psw),
        .o_psw(o_psw), .o_mem_wr_en(o_mem_wr_en), .o_ack_down(o_ack_down),
        .o_ack_valid(o_ack_valid), .o_ack_addr(o_ack_addr));

    pis_bus_partner i_far (.i_clk_sys(clk), .i_rst(rst), .i_post(post), .i_ack(o_ack_down),
        .o_req(p_req), .o_valid(p_valid), .o_addr(p_addr));

    // Clock and pulse counters
    always #10 clk = ~clk;
    always @(posedge clk) begin
        if (o_instr_exec === 1'b1) exec_cnt++;
        if (o_ack_valid === 1'b1) ack_cnt++;
        if (o_ack_down === 1'b1) down_cnt++;
        if (o_mem_wr_en === 1'b1) wr_cnt++;
    end

    task automatic test_done;
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            fails++;
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick

    // Waits for a status swap, then checks type, saved word and busy
    task automatic wait_swap(input logic [3:0] ty, input logic [23:0] old);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (o_swap_save !== 1'b1 && n < 40);
        chk(n, (n < 40) ? n : 0);
        if (n == 40) test_done();
        chk(o_swap_type, ty);
        chk(o_old_psw, old);
        chk(o_busy, 1'b1);
    endtask : wait_swap

    // Supplies the new status word while the core waits for it
    task automatic load(input logic [7:0] ctl, input logic [15:0] loc);
        @(negedge clk);
        new_psw.ctl = ctl;
        new_psw.loc = loc;
        new_psw_valid = 1'b1;
        tick(2);
        new_psw_valid = 1'b0;
        chk(o_psw, {ctl, loc});
        chk(o_busy, 1'b0);
    endtask : load

    // Waits until the given number of answers has been seen, then checks the held address
    task automatic wait_ack(input logic [7:0] exp, input int cnt);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (ack_cnt < cnt && n < 40);
        chk(n, (n < 40) ? n : 0);
        if (n == 40) test_done();
        chk(o_ack_addr, exp);
        tick(1);
    endtask : wait_ack

    task automatic wr_io(input logic cmd, input logic [7:0] addr, input logic [7:0] data);
        io = '{wr: ~cmd, cmd: cmd, addr: addr, data: data};
        tick(1);
        io = '0;
        tick(1);
    endtask : wr_io

    task automatic instr(input logic priv, input logic [15:0] len);
        instr_valid = 1'b1;
        instr_priv = priv;
        instr_len = len;
        tick(1);
        instr_valid = 1'b0;
    endtask : instr

    initial begin
        {clk, ce, instr_valid, instr_priv, ack_instr, new_psw_valid, mem_wr} = '0;
        {guard_hit, guard_arm, guard_en, post, instr_len, relay, base_sel} = '0;
        {evt, new_psw, io} = '0;
        rst = 1'b1;
        ce = 1'b1;
        tick(2);
        rst = 1'b0;
        tick(3);
        chk(o_psw, 24'h000000);
        evt.svc = 1'b1;
        tick(1);
        evt.svc = 1'b0;
        wait_swap(TY_SVC, 24'h000000);
        load(8'h80, 16'h0100);
        $display("test svc swap done");
        instr(1'b1, 16'h0004);
        wait_swap(TY_PROT, {8'h80, 16'h0100});
        chk(exec_cnt, 0);
        load(8'h12, 16'h0200);
        instr(1'b0, 16'h0004);
        tick(2);
        chk(exec_cnt, 1);
        chk(o_psw.loc, 16'h0204);
        evt.malf = 1'b1;
        tick(1);
        evt.malf = 1'b0;
        tick(8);
        chk(o_busy, 1'b0);
        $display("test protect and gating done");
        wr_io(1'b1, 8'h23, 8'h00);
        wr_io(1'b0, 8'h20, 8'h05);
        wr_io(1'b0, 8'h20, 8'h04);
        relay = 8'h0D;
        wait_ack(8'h22, 1);
        tick(10);
        chk(ack_cnt, 1);
        wr_io(1'b0, 8'h20, 8'h05);
        wr_io(1'b0, 8'h20, 8'h01);
        wait_ack(8'h20, 2);
        tick(10);
        chk(ack_cnt, 2);
        base_sel = 2'b11;
        tick(3);
        wr_io(1'b1, 8'h3A, 8'h00);
        wr_io(1'b0, 8'h38, 8'h80);
        wr_io(1'b0, 8'h38, 8'h80);
        relay = 8'h8D;
        wait_ack(8'h3F, 3);
        $display("test external module done");
        guard_arm = 1'b1;
        guard_en = 1'b1;
        mem_wr = 1'b1;
        guard_hit = 1'b1;
        post = 1'b1;
        tick(1);
        {mem_wr, guard_hit, post} = '0;
        wait_ack(GUARD, 4);
        wait_ack(8'h5C, 5);
        chk(down_cnt, 1);
        chk(wr_cnt, 0);
        mem_wr = 1'b1;
        tick(1);
        mem_wr = 1'b0;
        tick(2);
        chk(wr_cnt, 1);
        $display("test guard and chain done");
        evt.svc = 1'b1;
        tick(1);
        evt.svc = 1'b0;
        wait_swap(TY_SVC, {8'h12, 16'h0204});
        load(8'h02, 16'h0300);
        mem_wr = 1'b1;
        guard_hit = 1'b1;
        tick(1);
        {mem_wr, guard_hit} = '0;
        wait_swap(TY_EXT, {8'h02, 16'h0300});
        tick(1);
        ack_instr = 1'b1;
        tick(1);
        ack_instr = 1'b0;
        wait_ack(GUARD, 6);
        load(8'h02, 16'h0400);
        tick(4);
        chk(ack_cnt, 6);
        chk(wr_cnt, 1);
        $display("test acknowledge instruction done");
        test_done();
    end
endmodule : prioritized_interrupt_system_tb
`default_nettype wire
